// ---- logic/dgpwm_pkg.sv ----
package dgpwm_pkg;
    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int NUM_GEN = 2;
    localparam int NUM_OUT = 4;
    localparam int CNT_W   = 32;

    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [11:0] OFS_GEN_MODE  = 12'h000;
    localparam logic [11:0] OFS_GEN_MASK  = 12'h004;
    localparam logic [11:0] OFS_PERIOD    = 12'h008;
    localparam logic [11:0] OFS_OUT_MASK  = 12'h00c;
    localparam logic [11:0] OFS_WIDTH     = 12'h010;
    localparam logic [11:0] OFS_INVERT    = 12'h014;
    localparam logic [11:0] OFS_START     = 12'h018;
    localparam logic [11:0] OFS_STOP      = 12'h01c;
    localparam logic [11:0] OFS_DOUT      = 12'h020;
    localparam logic [11:0] OFS_STATUS    = 12'h024;
    localparam logic [11:0] OFS_IRQ_TRIG  = 12'h028;
    localparam logic [11:0] OFS_RISE_GRD  = 12'h02c;
    localparam logic [11:0] OFS_FALL_GRD  = 12'h030;
    localparam logic [11:0] OFS_GEN_STATE = 12'h034;

    // ----------------------------------------
    // generator mode field encodings
    // ----------------------------------------
    localparam logic [31:0] MODE_COUNT_DOWN_ONLY    = 32'h0000_0000;
    localparam logic [31:0] MODE_COUNT_UP_THEN_DOWN = 32'h0000_0002;
    localparam logic [31:0] MODE_DEFERRED_UPDATE    = 32'h0000_0038;
    localparam logic [31:0] MODE_INSTANT_UPDATE     = 32'h0000_0000;
    localparam int          MODE_UPDN_BIT           = 1;
    localparam int          MODE_DEFER_LSB          = 3;
    localparam logic [2:0]  MODE_DEFER_FIELD        = 3'h7;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [31:0] RST_PERIOD = 32'h0000_ffff;
    localparam logic [31:0] RST_WIDTH  = 32'h0000_0000;
endpackage

// ---- logic/dgpwm_cfg_if.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// configuration path from register file to one generator
// ----------------------------------------
interface dgpwm_cfg_if;
    logic        up_down;
    logic        deferred;
    logic        run;
    logic [31:0] period;
    logic [31:0] width0;
    logic [31:0] width1;
    logic        up_dn_dir;
    logic [1:0]  wave;
    modport ctrl (output up_down, output deferred, output run, output period,
                  output width0, output width1, input up_dn_dir, input wave);
    modport gen  (input up_down, input deferred, input run, input period,
                  input width0, input width1, output up_dn_dir, output wave);
endinterface

// ---- logic/dgpwm_gen.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// one generator block: one counter, two outputs
// ----------------------------------------
module dgpwm_gen
    import dgpwm_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    dgpwm_cfg_if.gen  cfg
);
    typedef struct packed {
        logic [31:0] count;
        logic        dir_up;
        logic [31:0] period;
        logic [31:0] width0;
        logic [31:0] width1;
        logic [1:0]  wave;
    } dgpwm_gen_t;

    dgpwm_gen_t st_reg;
    dgpwm_gen_t st_next;
    logic       reload;

    // counter, shadow load and compare
    always_comb begin
        st_next = st_reg;
        reload  = 1'b0;
        if (!cfg.run) begin
            st_next.count  = '0;
            st_next.dir_up = 1'b1;
            reload         = 1'b1;
        end else if (cfg.up_down) begin
            // triangle counting gives centred pulses
            if (st_reg.dir_up) begin
                if (st_reg.count >= st_reg.period - 32'h0000_0001) begin
                    st_next.dir_up = 1'b0;
                    st_next.count  = st_reg.count - 32'h0000_0001;
                end else begin
                    st_next.count = st_reg.count + 32'h0000_0001;
                end
            end else if (st_reg.count == '0) begin
                st_next.dir_up = 1'b1;
                st_next.count  = 32'h0000_0001;
                reload         = 1'b1;
            end else begin
                st_next.count = st_reg.count - 32'h0000_0001;
            end
        end else begin
            st_next.dir_up = 1'b0;
            if (st_reg.count == '0) begin
                st_next.count = cfg.period - 32'h0000_0001;
                reload        = 1'b1;
            end else begin
                st_next.count = st_reg.count - 32'h0000_0001;
            end
        end
        // deferred vs instant update
        if (!cfg.deferred || reload) begin
            st_next.period = cfg.period;
            st_next.width0 = cfg.width0;
            st_next.width1 = cfg.width1;
        end
        // both outputs from the single counter
        st_next.wave[0] = cfg.run && (st_next.count < st_next.width0);
        st_next.wave[1] = cfg.run && (st_next.count < st_next.width1);
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_reg <= '{count: 32'h0000_0000, dir_up: 1'b1, period: RST_PERIOD,
                        width0: RST_WIDTH, width1: RST_WIDTH, wave: 2'h0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign cfg.up_dn_dir = st_reg.dir_up;
    assign cfg.wave      = st_reg.wave;
endmodule // dgpwm_gen

// ---- logic/dgpwm_top.sv ----
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
module dgpwm_top
    import dgpwm_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [3:0]  isolated_line_out
);
    // ----------------------------------------
    // register state
    // ----------------------------------------
    typedef struct packed {
        logic [NUM_GEN-1:0][31:0] gen_mode;
        logic [NUM_GEN-1:0][31:0] period;
        logic [NUM_OUT-1:0][31:0] width;
        logic [NUM_GEN-1:0]       generator_mask;
        logic [NUM_OUT-1:0]       output_mask;
        logic [NUM_OUT-1:0]       invert_outputs;
        logic [NUM_OUT-1:0]       pwm_sel;
        logic [NUM_OUT-1:0]       dout;
        logic [31:0]              irq_trigger_select;
        logic [31:0]              rise_guard_time;
        logic [31:0]              fall_guard_time;
        logic [31:0]              rdata;
        logic [3:0]               line;
    } dgpwm_regs_t;

    dgpwm_regs_t         r_reg;
    dgpwm_regs_t         r_next;
    logic                wr_en;
    logic                rd_en;
    logic                addr_ok;
    logic [NUM_OUT-1:0]  wave_all;
    logic [NUM_GEN-1:0]  gen_run;
    logic [NUM_GEN-1:0]  gen_dir;

    // ----------------------------------------
    // generators
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_GEN; g++) begin : gen_blk
            dgpwm_cfg_if cfg_if ();
            // generator runs while either of its lines is started
            assign gen_run[g]      = |r_reg.pwm_sel[2*g +: 2];
            assign cfg_if.run      = gen_run[g];
            assign cfg_if.up_down  = r_reg.gen_mode[g][MODE_UPDN_BIT];
            assign cfg_if.deferred = r_reg.gen_mode[g][MODE_DEFER_LSB +: 3] == MODE_DEFER_FIELD;
            assign cfg_if.period   = r_reg.period[g];
            assign cfg_if.width0   = r_reg.width[2*g];
            assign cfg_if.width1   = r_reg.width[2*g+1];
            assign wave_all[2*g +: 2] = cfg_if.wave;
            assign gen_dir[g]      = cfg_if.up_dn_dir;
            dgpwm_gen dgpwm_gen_i (
                .sys_clk (sys_clk),
                .sys_rst (sys_rst),
                .cfg     (cfg_if.gen)
            );
        end
    endgenerate

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    always_comb begin
        case (paddr)
            OFS_GEN_MODE, OFS_GEN_MASK, OFS_PERIOD, OFS_OUT_MASK, OFS_WIDTH,
            OFS_INVERT, OFS_START, OFS_STOP, OFS_DOUT, OFS_STATUS,
            OFS_IRQ_TRIG, OFS_RISE_GRD, OFS_FALL_GRD, OFS_GEN_STATE: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign rd_en   = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // ----------------------------------------
    // register writes, reads and line mux
    // ----------------------------------------
    always_comb begin
        r_next = r_reg;
        if (wr_en) begin
            case (paddr)
                OFS_GEN_MODE: begin
                    for (int i = 0; i < NUM_GEN; i++) begin
                        if (r_reg.generator_mask[i]) r_next.gen_mode[i] = pwdata;
                    end
                end
                OFS_GEN_MASK: r_next.generator_mask = pwdata[NUM_GEN-1:0];
                OFS_PERIOD: begin
                    for (int i = 0; i < NUM_GEN; i++) begin
                        if (r_reg.generator_mask[i]) r_next.period[i] = pwdata;
                    end
                end
                OFS_OUT_MASK: r_next.output_mask = pwdata[NUM_OUT-1:0];
                OFS_WIDTH: begin
                    for (int i = 0; i < NUM_OUT; i++) begin
                        if (r_reg.output_mask[i]) r_next.width[i] = pwdata;
                    end
                end
                OFS_INVERT: r_next.invert_outputs = pwdata[NUM_OUT-1:0];
                OFS_START: r_next.pwm_sel = r_reg.pwm_sel | pwdata[NUM_OUT-1:0];
                OFS_STOP:  r_next.pwm_sel = r_reg.pwm_sel & ~pwdata[NUM_OUT-1:0];
                OFS_DOUT:  r_next.dout = pwdata[NUM_OUT-1:0];
                OFS_IRQ_TRIG: r_next.irq_trigger_select = pwdata;
                OFS_RISE_GRD: r_next.rise_guard_time = pwdata;
                OFS_FALL_GRD: r_next.fall_guard_time = pwdata;
                default: ;
            endcase
        end
        // read data captured in setup phase, valid in access phase
        if (rd_en) begin
            case (paddr)
                OFS_GEN_MODE:  r_next.rdata = r_reg.gen_mode[0];
                OFS_GEN_MASK:  r_next.rdata = {30'h0, r_reg.generator_mask};
                OFS_PERIOD:    r_next.rdata = r_reg.period[0];
                OFS_OUT_MASK:  r_next.rdata = {28'h0, r_reg.output_mask};
                OFS_WIDTH:     r_next.rdata = r_reg.width[0];
                OFS_INVERT:    r_next.rdata = {28'h0, r_reg.invert_outputs};
                OFS_DOUT:      r_next.rdata = {28'h0, r_reg.dout};
                OFS_STATUS:    r_next.rdata = {20'h0, r_reg.line, wave_all, r_reg.pwm_sel};
                OFS_IRQ_TRIG:  r_next.rdata = r_reg.irq_trigger_select;
                OFS_RISE_GRD:  r_next.rdata = r_reg.rise_guard_time;
                OFS_FALL_GRD:  r_next.rdata = r_reg.fall_guard_time;
                OFS_GEN_STATE: r_next.rdata = {28'h0, gen_dir, gen_run};
                default:       r_next.rdata = 32'h0000_0000;
            endcase
        end
        // lines 0-3 carry waveform or plain value
        for (int i = 0; i < NUM_OUT; i++) begin
            r_next.line[i] = r_reg.pwm_sel[i] ? (wave_all[i] ^ r_reg.invert_outputs[i])
                                              : r_reg.dout[i];
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            r_reg <= '{gen_mode: '0, period: {NUM_GEN{RST_PERIOD}}, width: {NUM_OUT{RST_WIDTH}},
                       generator_mask: '0, output_mask: '0, invert_outputs: '0, pwm_sel: '0,
                       dout: '0, irq_trigger_select: '0, rise_guard_time: '0,
                       fall_guard_time: '0, rdata: '0, line: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign prdata            = r_reg.rdata;
    assign isolated_line_out = r_reg.line;
endmodule // dgpwm_top

// ---- dv/dgpwm_monitor.sv ----
`timescale 1ns/1ps
module dgpwm_monitor
    import dgpwm_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [3:0]  isolated_line_out
);
    logic [3:0] sel_h;
    logic [3:0] dout_h;
    logic       wr;
    logic       rd;
    logic       nomap;
    logic       mapped;
    // decode of bus phases
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign nomap = paddr > OFS_GEN_STATE && paddr[1:0] == 2'h0;
    assign mapped = paddr <= OFS_GEN_STATE && paddr[1:0] == 2'h0;
    // shadow of line selection and plain value
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sel_h <= 4'h0;
            dout_h <= 4'h0;
        end else if (wr) begin
            if (paddr == OFS_START) sel_h <= sel_h | pwdata[3:0];
            if (paddr == OFS_STOP) sel_h <= sel_h & ~pwdata[3:0];
            if (paddr == OFS_DOUT) dout_h <= pwdata[3:0];
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_ready_high: assert property (psel |-> pready)
        else $error("pready low in transfer");
    a_unmapped_err: assert property (psel && penable && nomap |-> pslverr)
        else $error("no error on unmapped access");
    a_mapped_ok: assert property (psel && penable && mapped |-> !pslverr)
        else $error("error on mapped access");
    a_prdata_holds: assert property (!rd |=> $stable(prdata))
        else $error("read data moved");
    a_cmd_zero: assert property (rd && (paddr == OFS_START || paddr == OFS_STOP) |=> prdata == 32'h0000_0000)
        else $error("command register read not zero");
    a_unmapped_zero: assert property (rd && nomap |=> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_plain_lines: assert property (((isolated_line_out ^ $past(dout_h)) & ~$past(sel_h)) == 4'h0)
        else $error("plain line differs from output value");
    a_sel_status: assert property (rd && paddr == OFS_STATUS |=> prdata[3:0] == $past(sel_h))
        else $error("status selection wrong");
endmodule // dgpwm_monitor

bind dgpwm_top dgpwm_monitor dgpwm_monitor_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .isolated_line_out(isolated_line_out));

// ---- dv/dgpwm_line_model.sv ----
`timescale 1ns/1ps
module dgpwm_line_model (
    input wire logic        sys_clk,
    input wire logic        clr,
    input wire logic [3:0]  line,
    output logic [3:0][15:0] high_cnt,
    output logic [3:0][15:0] rise_cnt
);
    logic [3:0] line_q;
    // per-line high time and edge tally seen by the drivers
    always_ff @(posedge sys_clk) begin
        line_q <= line;
        for (int i = 0; i < 4; i++) begin
            high_cnt[i] <= clr ? 16'h0000 : high_cnt[i] + 16'(line[i]);
            rise_cnt[i] <= clr ? 16'h0000 : rise_cnt[i] + 16'(line[i] && !line_q[i]);
        end
    end
endmodule // dgpwm_line_model

// ---- dv/test_dual_generator_pwm.sv ----
`timescale 1ns/1ps
module test_dual_generator_pwm
    import dgpwm_pkg::*;
;
    logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, clr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] line;
    logic [3:0][15:0] high_cnt, rise_cnt;
    int miscompares, n_tests, cycles;
    int wd [4] = '{3, 7, 5, 0};
    dgpwm_top dgpwm_top_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .isolated_line_out(line));
    dgpwm_line_model dgpwm_line_model_i (.sys_clk(sys_clk), .clr(clr), .line(line),
        .high_cnt(high_cnt), .rise_cnt(rise_cnt));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one apb transfer, waits for pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // settle, then tally n cycles of the lines
    task automatic measure(input int n);
        repeat (30) @(posedge sys_clk);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        apb(0, OFS_PERIOD, 32'h0000_0000);
        check("period", RST_PERIOD, rd);
        apb(0, OFS_WIDTH, 32'h0000_0000);
        check("width", RST_WIDTH, rd);
        apb(0, 12'h040, 32'h0000_0000);
        check("unmapped slverr", 32'h0000_0001, {31'h0, err});
    endtask
    task automatic t_plain();
        apb(1, OFS_DOUT, 32'h0000_000a);
        repeat (3) @(posedge sys_clk);
        check("plain lines", 32'h0000_000a, {28'h0, line});
    endtask
    task automatic t_down();
        apb(1, OFS_IRQ_TRIG, 32'h0000_0000);
        apb(1, OFS_RISE_GRD, 32'h0000_0000);
        apb(1, OFS_FALL_GRD, 32'h0000_0000);
        apb(1, OFS_GEN_MASK, 32'h0000_0003);
        apb(1, OFS_GEN_MODE, MODE_COUNT_DOWN_ONLY | MODE_INSTANT_UPDATE);
        apb(1, OFS_PERIOD, 32'h0000_000a);
        for (int i = 0; i < 4; i++) begin
            apb(1, OFS_OUT_MASK, 32'(1 << i));
            apb(1, OFS_WIDTH, 32'(wd[i]));
        end
        apb(1, OFS_START, 32'h0000_000f);
        measure(100);
        for (int i = 0; i < 4; i++) check("high time", 32'(wd[i] * 10), 32'(high_cnt[i]));
    endtask
    task automatic t_invert();
        apb(1, OFS_INVERT, 32'h0000_0009);
        measure(100);
        for (int i = 0; i < 4; i++) check("inverted", 32'((i % 3 == 0) ? 100 - wd[i] * 10 : wd[i] * 10),
            32'(high_cnt[i]));
        apb(1, OFS_INVERT, 32'h0000_0000);
    endtask
    task automatic t_updown();
        apb(1, OFS_GEN_MASK, 32'h0000_0002);
        apb(1, OFS_GEN_MODE, MODE_COUNT_UP_THEN_DOWN);
        apb(0, OFS_GEN_MODE, 32'h0000_0000);
        check("mode a kept", MODE_COUNT_DOWN_ONLY, rd);
        measure(180);
        check("rises a", 32'd18, 32'(rise_cnt[0]));
        check("rises b", 32'h0000_0001, {31'h0, rise_cnt[2] inside {16'd9, 16'd10}});
    endtask
    // deferred update: new width waits for the next reload
    task automatic t_defer();
        apb(1, OFS_GEN_MASK, 32'h0000_0001);
        apb(1, OFS_GEN_MODE, MODE_COUNT_DOWN_ONLY | MODE_DEFERRED_UPDATE);
        apb(1, OFS_PERIOD, 32'h0000_00c8);
        repeat (12) @(posedge sys_clk);
        apb(1, OFS_OUT_MASK, 32'h0000_0001);
        apb(1, OFS_WIDTH, 32'h0000_00c7);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        repeat (40) @(posedge sys_clk);
        @(negedge sys_clk);
        check("width held", 32'h0000_0000, 32'(high_cnt[0]));
        repeat (170) @(posedge sys_clk);
        measure(200);
        check("width at reload", 32'h0000_00c7, 32'(high_cnt[0]));
    endtask
    task automatic t_stop();
        apb(1, OFS_STOP, 32'h0000_0003);
        repeat (3) @(posedge sys_clk);
        check("stopped lines", 32'h0000_0002, {30'h0, line[1:0]});
        apb(0, OFS_STATUS, 32'h0000_0000);
        check("selection", 32'h0000_000c, {28'h0, rd[3:0]});
        apb(0, OFS_START, 32'h0000_0000);
        check("start read", 32'h0000_0000, rd);
    endtask
    // ----------------------------------------
    // clock, timeout, main sequence
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end
    initial begin
        {sys_rst, psel, penable, pwrite, clr} = 5'b10000;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        cycles = 0;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_plain();
        t_down();
        t_invert();
        t_updown();
        t_defer();
        t_stop();
        summarize();
    end
endmodule // test_dual_generator_pwm
